// >>> inc/wdrc_params.svh
// timing counts, offsets, field positions and reset values of the watchdog and reset control
`ifndef WDRC_PARAMS_SVH
`define WDRC_PARAMS_SVH
`define WDRC_CLK_MHZ           100
`define WDRC_OFF_CONTROL       12'h000
`define WDRC_OFF_STATUS        12'h004
`define WDRC_OFF_CMD           12'h008
`define WDRC_CONTROL_RESET     8'h53
`define WDRC_GUARD_MSB         7
`define WDRC_GUARD_LSB         3
`define WDRC_SRF_BIT           2
`define WDRC_PERIOD_MSB        1
`define WDRC_PERIOD_LSB        0
`define WDRC_STAGE_BASE        6
`define WDRC_GUARD_ENABLE      5'h0A
`define WDRC_GUARD_DISABLE     5'h15
`define WDRC_OSC_DIV           8
`define WDRC_SRESET_DELAY_US   1
`define WDRC_SRESET_CYCLES     ((`WDRC_SRESET_DELAY_US * `WDRC_CLK_MHZ))
`define WDRC_LVR_QUALIFY_US    1
`define WDRC_LVR_CYCLES        ((`WDRC_LVR_QUALIFY_US * `WDRC_CLK_MHZ))
`define WDRC_POR_DELAY_US      1
`define WDRC_POR_CYCLES        ((`WDRC_POR_DELAY_US * `WDRC_CLK_MHZ))
`define WDRC_RESP_OKAY         2'h0
`define WDRC_RESP_SLVERR       2'h2
`define WDRC_CMD_CLEAR_BIT     0
`define WDRC_CMD_HALT_BIT      1
`endif

// >>> inc/wdrc_pkg.sv
// types of the watchdog and reset control
`default_nettype none
package wdrc_pkg;
   typedef enum logic [1:0] {
      WDRC_FAST  = 2'h0,
      WDRC_SLOW  = 2'h1,
      WDRC_IDLE  = 2'h3,
      WDRC_SLEEP = 2'h2
   } wdrc_mode_e;
   typedef logic [15:0] wdrc_count_t;
endpackage : wdrc_pkg
`default_nettype wire

// >>> rtl/wdrc_top.sv
// watchdog timer with software reset, power-on and undervoltage reset sources, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "wdrc_params.svh"

module wdrc_top (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [11:0]         awaddr,
   input  wire logic                wvalid,
   output logic                     wready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   output logic                     bvalid,
   input  wire logic                bready,
   output logic [1:0]               bresp,
   input  wire logic                arvalid,
   output logic                     arready,
   input  wire logic [11:0]         araddr,
   output logic                     rvalid,
   input  wire logic                rready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   input  wire logic                slow_osc_tick,
   input  wire logic [1:0]          power_mode,
   input  wire logic                undervoltage_low,
   output logic                     device_reset,
   output logic                     pc_sp_clear,
   output logic                     port_preset,
   output logic                     timeout_flag,
   output logic                     power_down_flag
);
   localparam int SRESET_N = (`WDRC_SRESET_CYCLES < 1) ? 1 : `WDRC_SRESET_CYCLES;
   localparam int LVR_N    = (`WDRC_LVR_CYCLES < 1) ? 1 : `WDRC_LVR_CYCLES;
   localparam int POR_N    = (`WDRC_POR_CYCLES < 1) ? 1 : `WDRC_POR_CYCLES;

   logic [7:0]             watchdog_control;
   logic                   clear_cmd;
   logic                   halt_cmd;
   logic [2:0]             osc_div;
   logic                   wd_tick;
   wdrc_pkg::wdrc_count_t  wd_count;
   logic                   wd_overflow;
   logic [7:0]             srst_cnt;
   logic                   srst_fire;
   logic [7:0]             lvr_cnt;
   logic                   lvr_fire;
   logic [7:0]             por_cnt;
   logic                   por_done;
   logic                   aw_held;
   logic                   w_held;
   logic [11:0]            aw_addr_q;
   logic [31:0]            w_data_q;
   logic [3:0]             w_strb_q;
   logic                   do_write;
   logic                   ctrl_wr;
   logic                   cmd_wr;
   logic [7:0]             next_control;
   logic                   next_aw_held;
   logic                   next_w_held;
   logic                   next_bvalid;

   function automatic logic guard_legal(input logic [4:0] g);
      return (g == `WDRC_GUARD_ENABLE) || (g == `WDRC_GUARD_DISABLE);
   endfunction : guard_legal

   function automatic logic low_power(input wdrc_pkg::wdrc_mode_e m);
      return (m == wdrc_pkg::WDRC_IDLE) || (m == wdrc_pkg::WDRC_SLEEP);
   endfunction : low_power

   // ones below the overflow stage, counted in divided ticks
   function automatic wdrc_pkg::wdrc_count_t stage_mask(input logic [1:0] sel);
      return (16'h0001 << (`WDRC_STAGE_BASE + 2 * int'(sel))) - 16'h0001;
   endfunction : stage_mask

   wire logic [4:0] guard_code_field = watchdog_control[`WDRC_GUARD_MSB:`WDRC_GUARD_LSB];
   wire logic [1:0] period_select    = watchdog_control[`WDRC_PERIOD_MSB:`WDRC_PERIOD_LSB];
   wire logic       wd_enabled       = (guard_code_field == `WDRC_GUARD_ENABLE);
   wire wdrc_pkg::wdrc_mode_e mode   = wdrc_pkg::wdrc_mode_e'(power_mode);
   wire logic       any_reset        = srst_fire | lvr_fire | (wd_overflow & ~low_power(mode));

   // ---------------- AXI4-Lite write side ----------------
   assign do_write = aw_held & w_held & ~bvalid;
   assign ctrl_wr  = do_write & (aw_addr_q == `WDRC_OFF_CONTROL) & w_strb_q[0];
   assign cmd_wr   = do_write & (aw_addr_q == `WDRC_OFF_CMD) & w_strb_q[0];
   assign clear_cmd = cmd_wr & w_data_q[`WDRC_CMD_CLEAR_BIT];
   assign halt_cmd  = cmd_wr & w_data_q[`WDRC_CMD_HALT_BIT];

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_bvalid  = bvalid;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
      end
      if (do_write) begin
         next_bvalid  = 1'b1;
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `WDRC_RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         bvalid  <= next_bvalid;
         // readies taken from the next state so that the ports stay flop outputs
         awready <= ~next_aw_held & ~next_bvalid;
         wready  <= ~next_w_held & ~next_bvalid;
         if (awvalid && awready) begin
            aw_addr_q <= {awaddr[11:2], 2'h0};
         end
         if (wvalid && wready) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (do_write) begin
            bresp <= (aw_addr_q == `WDRC_OFF_CONTROL || aw_addr_q == `WDRC_OFF_CMD)
                     ? `WDRC_RESP_OKAY : `WDRC_RESP_SLVERR;
         end
      end
   end

   // ---------------- AXI4-Lite read side ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid  <= 1'b0;
         arready <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `WDRC_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid  <= 1'b1;
         arready <= 1'b0;
         rresp  <= `WDRC_RESP_OKAY;
         unique case ({araddr[11:2], 2'b00})
            `WDRC_OFF_CONTROL: rdata <= {24'h00_0000, watchdog_control};
            `WDRC_OFF_STATUS:  rdata <= {28'h000_0000, wd_enabled, power_down_flag,
                                         timeout_flag, device_reset};
            `WDRC_OFF_CMD:     rdata <= 32'h0000_0000;
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= `WDRC_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end else begin
         arready <= ~rvalid;
      end
   end

   // ---------------- control register ----------------
   always_comb begin
      next_control = watchdog_control;
      if (ctrl_wr) begin
         next_control = w_data_q[7:0];
         // flag can be cleared by software only, never set by it
         next_control[`WDRC_SRF_BIT] = watchdog_control[`WDRC_SRF_BIT] & w_data_q[`WDRC_SRF_BIT];
      end
      if (srst_fire) begin
         // device reset restores the power-on value, but the cause stays visible
         next_control = `WDRC_CONTROL_RESET;
         next_control[`WDRC_SRF_BIT] = 1'b1;
      end else if (any_reset) begin
         next_control = {`WDRC_CONTROL_RESET} | {5'h00, watchdog_control[`WDRC_SRF_BIT], 2'b00};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_control <= `WDRC_CONTROL_RESET;
      end else begin
         watchdog_control <= next_control;
      end
   end

   // ---------------- software reset delay ----------------
   // an illegal guard code arms the delay; it cannot be cancelled by rewriting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         srst_cnt  <= 8'h00;
         srst_fire <= 1'b0;
      end else begin
         srst_fire <= 1'b0;
         if (srst_fire) begin
            srst_cnt <= 8'h00;
         end else if (srst_cnt != 8'h00) begin
            if (srst_cnt == 8'(SRESET_N)) begin
               srst_fire <= 1'b1;
            end else begin
               srst_cnt <= srst_cnt + 8'h01;
            end
         end else if (!guard_legal(guard_code_field)) begin
            srst_cnt <= 8'h01;
         end
      end
   end

   // ---------------- watchdog counter ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_div <= 3'h0;
         wd_tick <= 1'b0;
      end else begin
         wd_tick <= 1'b0;
         if (slow_osc_tick) begin
            osc_div <= osc_div + 3'h1;
            wd_tick <= (osc_div == 3'(`WDRC_OSC_DIV - 1));
         end
      end
   end

   // overflow taken at stage 9/11/13/15 of the oscillator count, i.e. stage 6..12 after /8
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wd_count    <= 16'h0000;
         wd_overflow <= 1'b0;
      end else begin
         wd_overflow <= 1'b0;
         if (srst_fire || clear_cmd || halt_cmd || any_reset || wd_overflow) begin
            wd_count <= 16'h0000;
         end else if (wd_enabled && wd_tick) begin
            wd_count <= wd_count + 16'h0001;
            // all ones below the selected stage: this tick carries into it
            wd_overflow <= (wd_count & stage_mask(period_select)) ==
                           stage_mask(period_select);
         end
      end
   end

   // ---------------- undervoltage qualify ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvr_cnt  <= 8'h00;
         lvr_fire <= 1'b0;
      end else begin
         lvr_fire <= 1'b0;
         if (!undervoltage_low || low_power(mode) || lvr_fire) begin
            lvr_cnt <= 8'h00;
         end else if (lvr_cnt == 8'(LVR_N)) begin
            lvr_fire <= 1'b1;
            lvr_cnt  <= 8'h00;
         end else begin
            lvr_cnt <= lvr_cnt + 8'h01;
         end
      end
   end

   // ---------------- power-on delay and reset outputs ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         por_cnt  <= 8'h00;
         por_done <= 1'b0;
      end else if (!por_done) begin
         por_cnt  <= por_cnt + 8'h01;
         por_done <= (por_cnt == 8'(POR_N - 1));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         device_reset <= 1'b1;
         port_preset  <= 1'b1;
         pc_sp_clear  <= 1'b1;
      end else begin
         device_reset <= ~por_done | any_reset;
         port_preset  <= ~por_done | any_reset;
         pc_sp_clear  <= ~por_done | any_reset | (wd_overflow & low_power(mode));
      end
   end

   // ---------------- status flags ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_flag    <= 1'b0;
         power_down_flag <= 1'b0;
      end else begin
         if (wd_overflow) begin
            timeout_flag <= 1'b1;
         end else if (halt_cmd) begin
            timeout_flag <= 1'b0;
         end
         if (halt_cmd) begin
            power_down_flag <= 1'b1;
         end else if (clear_cmd) begin
            power_down_flag <= 1'b0;
         end
      end
   end

   // ---------------- assertions ----------------
   sequence s_bad_guard;
      !guard_legal(guard_code_field) && srst_cnt == 8'h00 && !srst_fire;
   endsequence

   a_guard_reset_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      s_bad_guard |-> ##[1:120] srst_fire)
      else $error("illegal guard code did not reset");
   a_srf_set: assert property (@(posedge aclk) disable iff (!aresetn)
      srst_fire |=> watchdog_control[`WDRC_SRF_BIT])
      else $error("soft reset flag not set");
   a_srf_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_control[`WDRC_SRF_BIT] && !ctrl_wr |=> watchdog_control[`WDRC_SRF_BIT])
      else $error("soft reset flag lost");
   a_disabled_stops: assert property (@(posedge aclk) disable iff (!aresetn)
      guard_code_field == `WDRC_GUARD_DISABLE |=> !wd_overflow)
      else $error("disabled watchdog overflowed");
   a_overflow_full: assert property (@(posedge aclk) disable iff (!aresetn)
      wd_overflow && !low_power(mode) |=> device_reset && timeout_flag)
      else $error("overflow gave no full reset");
   a_overflow_low: assert property (@(posedge aclk) disable iff (!aresetn)
      wd_overflow && low_power(mode) && !srst_fire && !lvr_fire |=>
      pc_sp_clear && !device_reset && timeout_flag)
      else $error("low power overflow wrong");
   a_clear_count: assert property (@(posedge aclk) disable iff (!aresetn)
      clear_cmd || halt_cmd |=> wd_count == 16'h0000)
      else $error("count not cleared");
   a_lvr_low_power: assert property (@(posedge aclk) disable iff (!aresetn)
      low_power(mode) |=> !lvr_fire)
      else $error("undervoltage reset in low power");
   a_pdf_halt: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_cmd |=> power_down_flag)
      else $error("power down flag not set");
   a_por_release: assert property (@(posedge aclk)
      !aresetn ##1 aresetn [*2] |-> device_reset && port_preset)
      else $error("power-on reset not held");
endmodule : wdrc_top
`default_nettype wire

// >>> verification/test_watchdog_and_reset_control.sv
// self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps
`default_nettype none
`include "wdrc_params.svh"
module test_watchdog_and_reset_control;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        slow_osc_tick = 1'b0, tick_on = 1'b0, undervoltage_low = 1'b0;
   logic [1:0]  power_mode = 2'h0;
   logic        device_reset, pc_sp_clear, port_preset, timeout_flag, power_down_flag;
   logic        seen_dr, seen_pc, flag_before;
   logic [31:0] rd;
   logic [1:0]  rsp;
   int          num_errors = 0;
   int          compares = 0;
   int          cnt;

   wdrc_top i_wdrc_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .slow_osc_tick(slow_osc_tick), .power_mode(power_mode),
      .undervoltage_low(undervoltage_low), .device_reset(device_reset),
      .pc_sp_clear(pc_sp_clear), .port_preset(port_preset), .timeout_flag(timeout_flag),
      .power_down_flag(power_down_flag));

   always #5 aclk = ~aclk;
   // a tick every other cycle keeps timeouts short while staying a one-cycle pulse
   always @(posedge aclk) slow_osc_tick <= tick_on & ~slow_osc_tick;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out

   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      // one edge apart from the previous release, so no signal is driven twice at once
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      axi_write(a, d, rsp);
      check({30'h0, rsp}, {30'h0, `WDRC_RESP_OKAY});
   endtask : wr

   task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
      axi_read(a, rd, rsp);
      check(rd, exp);
   endtask : rd_check

   task automatic watch(input int n);
      seen_dr = 1'b0;
      seen_pc = 1'b0;
      repeat (n) begin
         @(posedge aclk);
         if (device_reset === 1'b1) seen_dr = 1'b1;
         if (pc_sp_clear === 1'b1) seen_pc = 1'b1;
      end
   endtask : watch

   initial begin
      #500us;
      num_errors++;
      close_out();
   end

   initial begin
      repeat (12) @(posedge aclk);
      check({29'h0, device_reset, pc_sp_clear, port_preset}, 32'h7);
      check({30'h0, timeout_flag, power_down_flag}, 32'h0);
      aresetn <= 1'b1;
      cnt = 0;
      while (device_reset === 1'b1 && cnt < 300) begin
         @(posedge aclk);
         cnt++;
      end
      check({31'h0, cnt >= 99 && cnt <= 102}, 32'h1);
      rd_check(`WDRC_OFF_CONTROL, 32'h53);
      rd_check(`WDRC_OFF_STATUS, 32'h8);
      axi_read(12'h00C, rd, rsp);
      check({30'h0, rsp}, {30'h0, `WDRC_RESP_SLVERR});
      $display("test power_on done");
      // shortest period keeps a timeout inside a short run
      wr(`WDRC_OFF_CONTROL, 32'h50);
      rd_check(`WDRC_OFF_CONTROL, 32'h50);
      // periodic clears keep a running watchdog quiet
      tick_on <= 1'b1;
      repeat (5) begin
         wr(`WDRC_OFF_CMD, 32'h1);
         watch(400);
         check({31'h0, seen_dr}, 32'h0);
      end
      $display("test clear done");
      watch(1500);
      // a full reset restarts the program as well
      check({30'h0, seen_dr, seen_pc}, 32'h3);
      check({31'h0, timeout_flag}, 32'h1);
      tick_on <= 1'b0;
      repeat (10) @(posedge aclk);
      rd_check(`WDRC_OFF_CONTROL, 32'h53);
      $display("test fast_timeout done");
      wr(`WDRC_OFF_CMD, 32'h2);
      repeat (2) @(posedge aclk);
      check({30'h0, timeout_flag, power_down_flag}, 32'h1);
      wr(`WDRC_OFF_CMD, 32'h1);
      repeat (2) @(posedge aclk);
      check({31'h0, power_down_flag}, 32'h0);
      $display("test halt done");
      wr(`WDRC_OFF_CONTROL, 32'h50);
      power_mode <= 2'h3;
      tick_on <= 1'b1;
      watch(1500);
      check({30'h0, seen_dr, seen_pc}, 32'h1);
      check({31'h0, timeout_flag}, 32'h1);
      tick_on <= 1'b0;
      power_mode <= 2'h0;
      $display("test idle_timeout done");
      wr(`WDRC_OFF_CONTROL, 32'hA8);
      rd_check(`WDRC_OFF_CONTROL, 32'hA8);
      axi_read(`WDRC_OFF_STATUS, rd, rsp);
      check({31'h0, rd[3]}, 32'h0);
      tick_on <= 1'b1;
      watch(1500);
      check({31'h0, seen_dr}, 32'h0);
      tick_on <= 1'b0;
      wr(`WDRC_OFF_CONTROL, 32'h53);
      $display("test disable done");
      // guard code of zero is neither enable nor disable
      wr(`WDRC_OFF_CONTROL, 32'h03);
      watch(400);
      check({31'h0, seen_dr}, 32'h1);
      rd_check(`WDRC_OFF_CONTROL, 32'h57);
      wr(`WDRC_OFF_CONTROL, 32'h57);
      rd_check(`WDRC_OFF_CONTROL, 32'h57);
      wr(`WDRC_OFF_CONTROL, 32'h53);
      rd_check(`WDRC_OFF_CONTROL, 32'h53);
      $display("test guard_code done");
      flag_before = timeout_flag;
      undervoltage_low <= 1'b1;
      watch(50);
      undervoltage_low <= 1'b0;
      watch(150);
      check({31'h0, seen_dr}, 32'h0);
      undervoltage_low <= 1'b1;
      watch(250);
      undervoltage_low <= 1'b0;
      check({31'h0, seen_dr}, 32'h1);
      check({31'h0, timeout_flag}, {31'h0, flag_before});
      power_mode <= 2'h2;
      undervoltage_low <= 1'b1;
      watch(250);
      undervoltage_low <= 1'b0;
      check({31'h0, seen_dr}, 32'h0);
      power_mode <= 2'h0;
      $display("test undervoltage done");
      close_out();
   end
endmodule : test_watchdog_and_reset_control
`default_nettype wire
